// ===== include/fel_regs.svh
// register map, event codes and reset values of the fault and event logger
`ifndef FEL_REGS_SVH
`define FEL_REGS_SVH
`define FEL_DEPTH       10
`define FEL_OFS_CTRL    8'h00
`define FEL_OFS_STATUS  8'h04
`define FEL_OFS_OVHEAT  8'h08
`define FEL_OFS_OVOLT   8'h0C
`define FEL_OFS_UVOLT   8'h10
`define FEL_OFS_ERRLIM  8'h14
`define FEL_OFS_TMO     8'h18
`define FEL_OFS_ALMHIST 2'h1
`define FEL_OFS_WRNHIST 2'h2
`define FEL_OFS_COMHIST 2'h3
`define FEL_CTRL_CLRALM 0
`define FEL_CTRL_CLRWRN 1
`define FEL_CTRL_CLRCOM 2
`define FEL_CTRL_ALMRST 3
`define FEL_WRN_OVHEAT  8'h21
`define FEL_WRN_OVOLT   8'h22
`define FEL_WRN_UVOLT   8'h25
`define FEL_WRN_COMM    8'h84
`define FEL_ALM_COMM    8'h84
`define FEL_ALM_TMO     8'h85
`define FEL_CE_FRAME    8'h84
`define FEL_CE_UNDEF    8'h88
`define FEL_CE_TOOL     8'h89
`define FEL_CE_NVM      8'h8A
`define FEL_CE_RANGE    8'h8C
`define FEL_CE_STATE    8'h8D
`define FEL_OVHEAT_RST  16'hFFFF
`define FEL_OVOLT_RST   16'hFFFF
`define FEL_UVOLT_RST   16'h0000
`define FEL_ERRLIM_RST  8'h00
`define FEL_TMO_RST     32'h0000_0000
`endif

// ===== include/fel_pkg.sv
// types and history helpers of the fault and event logger
`include "fel_regs.svh"
package fel_pkg;
   localparam int DEPTH = `FEL_DEPTH;
   typedef logic [7:0]            fel_code_t;
   typedef logic [DEPTH-1:0][7:0] fel_hist_t;
   typedef logic [3:0]            fel_cnt_t;

   // newest entry sits at index 0, the oldest falls off the far end
   function automatic fel_hist_t felShiftIn(input fel_hist_t h, input fel_code_t c);
      return {h[DEPTH-2:0], c};
   endfunction

   // entry count saturates at the depth
   function automatic fel_cnt_t felBump(input fel_cnt_t n);
      return (n == fel_cnt_t'(DEPTH)) ? n : n + 4'h1;
   endfunction
endpackage

// ===== hdl/fel_logger.sv
// fault, warning and communication error logger with apb register access
`timescale 1ns/100ps
`include "fel_regs.svh"
// Behaviour
// [RULE1] alarm history keeps up to ten codes, newest first, surviving reset
// [RULE2] host reads alarm history and clears it through registers
// [RULE3] warning output high while any warning cause is present; motion unaffected
// [RULE4] warning output drops by itself once every cause is gone
// [RULE5] temperature above overheat threshold raises warning 21h
// [RULE6] supply above overvoltage raises 22h; below undervoltage raises 25h
// [RULE7] every link error raises warning 84h
// [RULE8] warning history keeps up to ten codes, newest first
// [RULE9] host reads warning history and clears it through registers
// [RULE10] warning history is empty after reset
// [RULE11] communication error log keeps ten codes, newest first, readable
// [RULE12] framing or block check error logs code 84h
// [RULE13] undefined command refused, logs 88h
// [RULE14] command during tool session refused, logs 89h
// [RULE15] command during nvm work, busy flag or nvm fault refused, logs 8Ah
// [RULE16] out of range setting refused, logs 8Ch
// [RULE17] command not executable in present state logs 8Dh
// [RULE18] host reads error log and clears it through registers
// [RULE19] communication error log is empty after reset
// [RULE20] consecutive link errors reaching limit raise alarm 84h
// [RULE21] timeout without valid communication raises alarm 85h
// [RULE22] full history drops oldest entry and stores new code as newest
module fel_logger #(
   parameter int TW = 16,
   parameter int VW = 16
) (
   input  wire logic          core_clk,
   input  wire logic          srst,
   input  wire logic          nvmBlank,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [11:0]   paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic [TW-1:0] temperature,
   input  wire logic [VW-1:0] supplyVoltage,
   input  wire logic          frameError,
   input  wire logic          bccError,
   input  wire logic          validComm,
   input  wire logic          cmdValid,
   input  wire logic          cmdDefined,
   input  wire logic          toolSession,
   input  wire logic          nvmBusy,
   input  wire logic          internalBusyFlag,
   input  wire logic          nvmFault,
   input  wire logic          cmdInRange,
   input  wire logic          cmdExecutable,
   input  wire logic          alarmValid,
   input  wire logic [7:0]    alarmCode,
   output logic               warningOutput,
   output logic               cmdAccept,
   output logic               cmdRefuse,
   output logic      [7:0]    refuseCode,
   output logic               commAlarm,
   output logic               timeoutAlarm
);
   // ***************************************************************
   // apb slave
   // ***************************************************************
   logic [TW-1:0]          ovheatQ;
   logic [VW-1:0]          ovoltQ, uvoltQ;
   logic [7:0]             errLimQ;
   logic [31:0]            tmoQ;
   fel_pkg::fel_hist_t     almHistQ, wrnHistQ, comHistQ;
   fel_pkg::fel_cnt_t      almCntQ, wrnCntQ, comCntQ;
   logic [3:0]             wrnLvl;
   logic                   commErr, apbDone, wrCtrl;
   logic [31:0]            rdVal;
   logic                   rdErr;

   assign commErr = frameError | bccError;
   assign apbDone = psel & penable & pready;
   assign wrCtrl  = apbDone & pwrite & (paddr[7:0] == `FEL_OFS_CTRL) & (paddr[11:8] == 4'h0);

   // read decode; unmapped or out of range history slots answer with pslverr
   always_comb begin
      rdVal = 32'h0000_0000;
      rdErr = 1'b0;
      if (paddr[11:8] != 4'h0 || paddr[1:0] != 2'h0) begin
         rdErr = 1'b1;
      end else if (paddr[7:6] != 2'h0) begin
         if (paddr[5:2] >= 4'(fel_pkg::DEPTH)) begin
            rdErr = 1'b1;
         end else if (paddr[7:6] == `FEL_OFS_ALMHIST) begin
            rdVal = {24'h00_0000, almHistQ[paddr[5:2]]}; // [RULE2]
         end else if (paddr[7:6] == `FEL_OFS_WRNHIST) begin
            rdVal = {24'h00_0000, wrnHistQ[paddr[5:2]]}; // [RULE9]
         end else begin
            rdVal = {24'h00_0000, comHistQ[paddr[5:2]]}; // [RULE11]
         end
      end else begin
         case (paddr[7:0])
            `FEL_OFS_CTRL:   rdVal = 32'h0000_0000;
            `FEL_OFS_STATUS: rdVal = {10'h000, timeoutAlarm, commAlarm, comCntQ, wrnCntQ,
                                      almCntQ, 3'h0, wrnLvl, warningOutput};
            `FEL_OFS_OVHEAT: rdVal = 32'(ovheatQ);
            `FEL_OFS_OVOLT:  rdVal = 32'(ovoltQ);
            `FEL_OFS_UVOLT:  rdVal = 32'(uvoltQ);
            `FEL_OFS_ERRLIM: rdVal = {24'h00_0000, errLimQ};
            `FEL_OFS_TMO:    rdVal = tmoQ;
            default:         rdErr = 1'b1;
         endcase
      end
   end

   // one wait state: pready rises in the second access cycle, from a flop
   always_ff @(posedge core_clk) begin
      if (srst || !(psel && penable) || pready) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= 1'b1;
         prdata  <= pwrite ? 32'h0000_0000 : rdVal;
         pslverr <= rdErr;
      end
   end

   // threshold and limit registers, written at the completing edge only
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ovheatQ <= `FEL_OVHEAT_RST;
         ovoltQ  <= `FEL_OVOLT_RST;
         uvoltQ  <= `FEL_UVOLT_RST;
         errLimQ <= `FEL_ERRLIM_RST;
         tmoQ    <= `FEL_TMO_RST;
      end else if (apbDone && pwrite && !pslverr) begin
         case (paddr[7:0])
            `FEL_OFS_OVHEAT: ovheatQ <= pwdata[TW-1:0];
            `FEL_OFS_OVOLT:  ovoltQ  <= pwdata[VW-1:0];
            `FEL_OFS_UVOLT:  uvoltQ  <= pwdata[VW-1:0];
            `FEL_OFS_ERRLIM: errLimQ <= pwdata[7:0];
            `FEL_OFS_TMO:    tmoQ    <= pwdata;
            default:         ;
         endcase
      end
   end

   // ***************************************************************
   // warnings
   // ***************************************************************
   logic [3:0] wrnLvlQ, wrnPendQ, wrnRise, wrnTake;
   fel_pkg::fel_code_t wrnCode;

   // level causes: bit0 overheat, bit1 overvoltage, bit2 undervoltage, bit3 link
   assign wrnLvl[0] = temperature > ovheatQ;   // [RULE5]
   assign wrnLvl[1] = supplyVoltage > ovoltQ;  // [RULE6]
   assign wrnLvl[2] = supplyVoltage < uvoltQ;  // [RULE6]
   assign wrnLvl[3] = commErr;                 // [RULE7]
   assign wrnRise   = wrnLvl & ~wrnLvlQ;

   // output only flags the condition; nothing here touches motor drive
   always_ff @(posedge core_clk) begin
      if (srst) begin
         warningOutput <= 1'b0;
         wrnLvlQ       <= 4'h0;
      end else begin
         warningOutput <= |wrnLvl; // [RULE3] [RULE4]
         wrnLvlQ       <= wrnLvl & 4'h7; // link errors log every event, not edges
      end
   end

   // simultaneous causes queue as pending bits and drain one per cycle
   always_comb begin
      wrnTake = 4'h0;
      wrnCode = `FEL_WRN_OVHEAT;
      if (wrnPendQ[3]) begin
         wrnTake = 4'h8;
         wrnCode = `FEL_WRN_COMM;
      end else if (wrnPendQ[0]) begin
         wrnTake = 4'h1;
         wrnCode = `FEL_WRN_OVHEAT;
      end else if (wrnPendQ[1]) begin
         wrnTake = 4'h2;
         wrnCode = `FEL_WRN_OVOLT;
      end else if (wrnPendQ[2]) begin
         wrnTake = 4'h4;
         wrnCode = `FEL_WRN_UVOLT;
      end
   end

   // new events win over the drain of the same bit
   always_ff @(posedge core_clk) begin
      if (srst) begin
         wrnPendQ <= 4'h0;
      end else begin
         wrnPendQ <= (wrnPendQ & ~wrnTake) | wrnRise;
      end
   end

   // warning history is volatile and emptied by reset
   always_ff @(posedge core_clk) begin
      if (srst) begin
         wrnHistQ <= '0; // [RULE10]
         wrnCntQ  <= 4'h0;
      end else if (wrnTake != 4'h0) begin
         wrnHistQ <= fel_pkg::felShiftIn(wrCtrl && pwdata[`FEL_CTRL_CLRWRN] ? '0 : wrnHistQ,
                                         wrnCode); // [RULE8] [RULE22]
         wrnCntQ  <= wrCtrl && pwdata[`FEL_CTRL_CLRWRN] ? 4'h1 : fel_pkg::felBump(wrnCntQ);
      end else if (wrCtrl && pwdata[`FEL_CTRL_CLRWRN]) begin
         wrnHistQ <= '0; // [RULE9]
         wrnCntQ  <= 4'h0;
      end
   end

   // ***************************************************************
   // command screening and communication error log
   // ***************************************************************
   fel_pkg::fel_code_t ceCode;
   logic               ceRefuse;

   // first failing check decides the refusal code
   always_comb begin
      ceRefuse = 1'b1;
      ceCode   = `FEL_CE_UNDEF;
      if (!cmdDefined) begin
         ceCode = `FEL_CE_UNDEF; // [RULE13]
      end else if (toolSession) begin
         ceCode = `FEL_CE_TOOL; // [RULE14]
      end else if (nvmBusy || internalBusyFlag || nvmFault) begin
         ceCode = `FEL_CE_NVM; // [RULE15]
      end else if (!cmdInRange) begin
         ceCode = `FEL_CE_RANGE; // [RULE16]
      end else if (!cmdExecutable) begin
         ceCode = `FEL_CE_STATE; // [RULE17]
      end else begin
         ceRefuse = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         cmdAccept  <= 1'b0;
         cmdRefuse  <= 1'b0;
         refuseCode <= 8'h00;
      end else begin
         cmdAccept  <= cmdValid & ~ceRefuse;
         cmdRefuse  <= cmdValid & ceRefuse;
         refuseCode <= (cmdValid && ceRefuse) ? ceCode : refuseCode;
      end
   end

   // a damaged frame carries no command, so frame errors take the slot
   logic               comPush;
   fel_pkg::fel_code_t comCode;
   assign comPush = commErr | (cmdValid & ceRefuse);
   assign comCode = commErr ? `FEL_CE_FRAME : ceCode; // [RULE12]

   always_ff @(posedge core_clk) begin
      if (srst) begin
         comHistQ <= '0; // [RULE19]
         comCntQ  <= 4'h0;
      end else if (comPush) begin
         comHistQ <= fel_pkg::felShiftIn(wrCtrl && pwdata[`FEL_CTRL_CLRCOM] ? '0 : comHistQ,
                                         comCode); // [RULE11] [RULE22]
         comCntQ  <= wrCtrl && pwdata[`FEL_CTRL_CLRCOM] ? 4'h1 : fel_pkg::felBump(comCntQ);
      end else if (wrCtrl && pwdata[`FEL_CTRL_CLRCOM]) begin
         comHistQ <= '0; // [RULE18]
         comCntQ  <= 4'h0;
      end
   end

   // ***************************************************************
   // link alarms and alarm history
   // ***************************************************************
   logic [7:0]  errRunQ;
   logic [31:0] tmoCntQ;
   logic        raiseComm, raiseTmo;
   logic [2:0]  almPendQ, almTake;
   fel_pkg::fel_code_t extCodeQ, almCode;

   assign raiseComm = commErr && !commAlarm && errLimQ != 8'h00 && (errRunQ + 8'h01) == errLimQ;
   assign raiseTmo  = !validComm && !timeoutAlarm && tmoQ != 32'h0 && (tmoCntQ + 32'h1) == tmoQ;

   // consecutive error run ends at the next good frame
   always_ff @(posedge core_clk) begin
      if (srst || validComm) begin
         errRunQ <= 8'h00;
      end else if (commErr && errRunQ != 8'hFF) begin
         errRunQ <= errRunQ + 8'h01;
      end
   end

   // silence counter; zero timeout register disables it
   always_ff @(posedge core_clk) begin
      if (srst || validComm || tmoQ == 32'h0 || timeoutAlarm) begin
         tmoCntQ <= 32'h0;
      end else begin
         tmoCntQ <= tmoCntQ + 32'h1;
      end
   end

   // alarm flags hold until the alarm reset bit; raising wins over reset
   always_ff @(posedge core_clk) begin
      if (srst) begin
         commAlarm    <= 1'b0;
         timeoutAlarm <= 1'b0;
      end else begin
         commAlarm    <= raiseComm | (commAlarm & ~(wrCtrl & pwdata[`FEL_CTRL_ALMRST])); // [RULE20]
         timeoutAlarm <= raiseTmo | (timeoutAlarm & ~(wrCtrl & pwdata[`FEL_CTRL_ALMRST])); // [RULE21]
      end
   end

   // pending alarm slots: bit0 external, bit1 link errors, bit2 timeout
   always_comb begin
      almTake = 3'h0;
      almCode = extCodeQ;
      if (almPendQ[1]) begin
         almTake = 3'h2;
         almCode = `FEL_ALM_COMM;
      end else if (almPendQ[2]) begin
         almTake = 3'h4;
         almCode = `FEL_ALM_TMO;
      end else if (almPendQ[0]) begin
         almTake = 3'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         almPendQ <= 3'h0;
         extCodeQ <= 8'h00;
      end else begin
         almPendQ <= (almPendQ & ~almTake) | {raiseTmo, raiseComm, alarmValid};
         extCodeQ <= alarmValid ? alarmCode : extCodeQ;
      end
   end

   // non-volatile image: srst wipes it only when the store reports blank
   always_ff @(posedge core_clk) begin
      if (srst && nvmBlank) begin
         almHistQ <= '0;
         almCntQ  <= 4'h0;
      end else if (srst) begin
         almHistQ <= almHistQ; // [RULE1]
      end else if (almTake != 3'h0) begin
         almHistQ <= fel_pkg::felShiftIn(wrCtrl && pwdata[`FEL_CTRL_CLRALM] ? '0 : almHistQ,
                                         almCode); // [RULE1] [RULE22]
         almCntQ  <= wrCtrl && pwdata[`FEL_CTRL_CLRALM] ? 4'h1 : fel_pkg::felBump(almCntQ);
      end else if (wrCtrl && pwdata[`FEL_CTRL_CLRALM]) begin
         almHistQ <= '0; // [RULE2]
         almCntQ  <= 4'h0;
      end
   end

   // ***************************************************************
   // checks
   // ***************************************************************
   chk_warn_follow: assert property (@(posedge core_clk) disable iff (srst) // [RULE3]
      (|wrnLvl) |=> warningOutput) else $error("warning output missed a cause");
   chk_warn_release: assert property (@(posedge core_clk) disable iff (srst) // [RULE4]
      !(|wrnLvl) ##1 !(|wrnLvl) |-> !warningOutput) else $error("warning output stuck");
   chk_undef_refuse: assert property (@(posedge core_clk) disable iff (srst) // [RULE13]
      cmdValid && !cmdDefined |=> cmdRefuse && refuseCode == `FEL_CE_UNDEF)
      else $error("undefined command not refused");
   chk_busy_refuse: assert property (@(posedge core_clk) disable iff (srst) // [RULE15]
      cmdValid && cmdDefined && !toolSession && (nvmBusy || internalBusyFlag || nvmFault)
      |=> cmdRefuse && refuseCode == `FEL_CE_NVM) else $error("busy command not refused");
   chk_frame_log: assert property (@(posedge core_clk) disable iff (srst) // [RULE12]
      commErr |=> comHistQ[0] == `FEL_CE_FRAME && comCntQ != 4'h0)
      else $error("frame error not logged");
   chk_good_accept: assert property (@(posedge core_clk) disable iff (srst) // [RULE17]
      cmdValid && !ceRefuse |=> cmdAccept && !cmdRefuse) else $error("good command refused");
   chk_com_clear: assert property (@(posedge core_clk) disable iff (srst) // [RULE18]
      wrCtrl && pwdata[`FEL_CTRL_CLRCOM] && !comPush |=> comCntQ == 4'h0)
      else $error("error log not cleared");
   chk_hist_cap: assert property (@(posedge core_clk) disable iff (srst) // [RULE8]
      wrnCntQ <= 4'(fel_pkg::DEPTH) && comCntQ <= 4'(fel_pkg::DEPTH))
      else $error("history count past depth");
   chk_shift_old: assert property (@(posedge core_clk) disable iff (srst) // [RULE22]
      comPush && !wrCtrl |=> comHistQ[1] == $past(comHistQ[0])) else $error("log not shifted");
   chk_comm_alarm: assert property (@(posedge core_clk) disable iff (srst) // [RULE20]
      raiseComm |=> commAlarm && almPendQ[1]) else $error("link alarm not raised");
   chk_apb_wait: assert property (@(posedge core_clk) disable iff (srst)
      psel && penable && !pready |=> pready) else $error("apb answer late");

   cov_refuse: cover property (@(posedge core_clk) disable iff (srst) cmdRefuse);
   cov_wrn_full: cover property (@(posedge core_clk) disable iff (srst)
      wrnCntQ == 4'(fel_pkg::DEPTH) && wrnTake != 4'h0);
   cov_tmo: cover property (@(posedge core_clk) disable iff (srst) $rose(timeoutAlarm));
endmodule

// ===== bench/fel_host_model.sv
// host side model: decoded commands and link frame events
`timescale 1ns/100ps
module fel_host_model (
   input  wire logic core_clk,
   output logic      cmdValid,
   output logic      cmdDefined,
   output logic      toolSession,
   output logic      nvmBusy,
   output logic      internalBusyFlag,
   output logic      nvmFault,
   output logic      cmdInRange,
   output logic      cmdExecutable,
   output logic      frameError,
   output logic      bccError,
   output logic      validComm
);
   // ************************************
   // command and frame stimulus
   // ************************************
   // idle link and no command at time zero; qualifiers only mean something with cmdValid
   initial begin
      cmdValid = 1'b0;
      {cmdDefined, toolSession, nvmBusy, internalBusyFlag, nvmFault} = 5'h00;
      {cmdInRange, cmdExecutable} = 2'h0;
      {frameError, bccError, validComm} = 3'h0;
   end

   // qualifiers flip after the sampling edge so stale levels never pass for fresh ones
   task automatic sendCmd(input logic [2:0] kind);
      @(posedge core_clk);
      cmdValid         <= 1'b1;
      cmdDefined       <= kind != 3'h1;
      toolSession      <= kind == 3'h2;
      nvmBusy          <= kind == 3'h3;
      internalBusyFlag <= kind == 3'h4;
      nvmFault         <= kind == 3'h5;
      cmdInRange       <= kind != 3'h6;
      cmdExecutable    <= kind != 3'h7;
      @(posedge core_clk);
      cmdValid         <= 1'b0;
      cmdDefined       <= ~cmdDefined;
      toolSession      <= ~toolSession;
      nvmBusy          <= ~nvmBusy;
      internalBusyFlag <= ~internalBusyFlag;
      nvmFault         <= ~nvmFault;
      cmdInRange       <= ~cmdInRange;
      cmdExecutable    <= ~cmdExecutable;
   endtask

   // one frame event: bit2 framing, bit1 block check, bit0 good frame
   task automatic sendLink(input logic [2:0] ev);
      @(posedge core_clk);
      {frameError, bccError, validComm} <= ev;
      @(posedge core_clk);
      {frameError, bccError, validComm} <= 3'h0;
   endtask
endmodule

// ===== bench/fault_event_logger_test.sv
// self-checking bench of the fault and event logger
`timescale 1ns/100ps
module fault_event_logger_test;
   // ************************************
   // stimulus, model and checks
   // ************************************
   logic        core_clk = 1'b0;
   logic        srst     = 1'b1;
   logic        nvmBlank = 1'b1;
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic [11:0] paddr    = 12'h000;
   logic [31:0] pwdata   = 32'h0000_0000;
   logic [15:0] temperature   = 16'h0000;
   logic [15:0] supplyVoltage = 16'h00C8;
   logic        alarmValid    = 1'b0;
   logic [7:0]  alarmCode     = 8'h00;
   wire  [31:0] prdata;
   wire  [7:0]  refuseCode;
   wire         pready, pslverr, warningOutput, cmdAccept, cmdRefuse, commAlarm;
   wire         timeoutAlarm, frameError, bccError, validComm, cmdValid, cmdDefined;
   wire         toolSession, nvmBusy, internalBusyFlag, nvmFault, cmdInRange, cmdExecutable;
   int          mismatches = 0;
   int          nTests     = 0;
   int          seed       = 45340;
   logic [7:0]  commQ[$];
   logic [7:0]  almQ[$];
   logic [31:0] rd;
   logic        err;
   localparam logic [7:0] REFC [8] = '{8'h00, 8'h88, 8'h89, 8'h8A, 8'h8A, 8'h8A, 8'h8C, 8'h8D};

   fel_logger dut (.core_clk, .srst, .nvmBlank, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .temperature, .supplyVoltage, .frameError,
      .bccError, .validComm, .cmdValid, .cmdDefined, .toolSession, .nvmBusy, .internalBusyFlag,
      .nvmFault, .cmdInRange, .cmdExecutable, .alarmValid, .alarmCode, .warningOutput,
      .cmdAccept, .cmdRefuse, .refuseCode, .commAlarm, .timeoutAlarm);

   fel_host_model host (.core_clk, .cmdValid, .cmdDefined, .toolSession, .nvmBusy,
      .internalBusyFlag, .nvmFault, .cmdInRange, .cmdExecutable, .frameError, .bccError,
      .validComm);

   // 125 MHz core clock
   always #4 core_clk = ~core_clk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      nTests++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", nTests, mismatches);
      if (mismatches == 0 && nTests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         chk(32'h0, 32'h1);
         test_done();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   // newest first, oldest drops out once ten are held
   task automatic addQ(ref logic [7:0] q[$], input logic [7:0] c);
      q.push_front(c);
      if (q.size() > 10) begin
         void'(q.pop_back());
      end
   endtask

   task automatic chkHist(input logic [11:0] base, ref logic [7:0] q[$]);
      for (int k = 0; k < 10; k++) begin
         rdChk(base + 12'(4 * k), (k < q.size()) ? {24'h0, q[k]} : 32'h0);
      end
   endtask

   // status word with every cause idle and only the alarm count set
   function automatic logic [31:0] statExp(input int a);
      return {20'h0, 4'(a), 8'h00};
   endfunction

   // hang guard
   initial begin
      cyc(100000);
      chk(32'h0, 32'h1);
      test_done();
   end

   // main sequence
   initial begin
      cyc(20);
      srst <= 1'b0;
      rdChk(12'h004, statExp(0));
      rdChk(12'h008, 32'h0000_FFFF);
      rdChk(12'h00C, 32'h0000_FFFF);
      rdChk(12'h010, 32'h0000_0000);
      apb(1'b0, 12'h0E8, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, 12'h008, 32'h0000_0064);
      apb(1'b1, 12'h00C, 32'h0000_012C);
      apb(1'b1, 12'h010, 32'h0000_0064);
      temperature <= 16'h0065 + 16'($random(seed) & 32'h0FFF);
      cyc(6);
      chk(warningOutput, 1'b1);
      temperature <= 16'h0000;
      cyc(6);
      chk(warningOutput, 1'b0);
      supplyVoltage <= 16'h012D + 16'($random(seed) & 32'h0FFF);
      cyc(6);
      chk(warningOutput, 1'b1);
      supplyVoltage <= 16'h00C8;
      cyc(6);
      supplyVoltage <= 16'($random(seed) & 32'h003F);
      cyc(6);
      chk(warningOutput, 1'b1);
      supplyVoltage <= 16'h00C8;
      cyc(6);
      chk(warningOutput, 1'b0);
      rdChk(12'h080, 32'h25);
      rdChk(12'h084, 32'h22);
      rdChk(12'h088, 32'h21);
      for (int i = 0; i < 8; i++) begin
         host.sendCmd(3'(i));
         #1;
         chk({cmdAccept, cmdRefuse}, (i == 0) ? 2'b10 : 2'b01);
         if (i > 0) begin
            chk(refuseCode, REFC[i]);
            addQ(commQ, REFC[i]);
         end
      end
      // two bad frames, then two more to push the log past full
      repeat (2) begin
         host.sendLink(3'b100);
         host.sendLink(3'b010);
         addQ(commQ, 8'h84);
         addQ(commQ, 8'h84);
         cyc(6);
         rdChk(12'h080, 32'h84);
         chkHist(12'h0C0, commQ);
      end
      // random alarm codes, more than the history holds
      repeat (12) begin
         @(posedge core_clk);
         alarmCode  <= 8'($random(seed));
         alarmValid <= 1'b1;
         @(posedge core_clk);
         alarmValid <= 1'b0;
         cyc(4);
         addQ(almQ, alarmCode);
      end
      chkHist(12'h040, almQ);
      host.sendLink(3'b001);
      apb(1'b1, 12'h014, 32'h3);
      host.sendLink(3'b100);
      host.sendLink(3'b100);
      cyc(4);
      chk(commAlarm, 1'b0);
      host.sendLink(3'b100);
      cyc(4);
      chk(commAlarm, 1'b1);
      addQ(almQ, 8'h84);
      apb(1'b1, 12'h018, 32'h0000_0014);
      host.sendLink(3'b001);
      cyc(10);
      chk(timeoutAlarm, 1'b0);
      cyc(20);
      chk(timeoutAlarm, 1'b1);
      addQ(almQ, 8'h85);
      apb(1'b1, 12'h018, 32'h0);
      apb(1'b1, 12'h014, 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd[21:20], 2'b11);
      apb(1'b1, 12'h000, 32'h8);
      cyc(2);
      chk({timeoutAlarm, commAlarm}, 2'b00);
      // power cycle with the alarm store kept
      nvmBlank <= 1'b0;
      srst     <= 1'b1;
      cyc(3);
      srst     <= 1'b0;
      chkHist(12'h040, almQ);
      rdChk(12'h004, statExp(almQ.size()));
      apb(1'b1, 12'h000, 32'h7);
      rdChk(12'h004, statExp(0));
      rdChk(12'h040, 32'h0);
      test_done();
   end
endmodule
